// ---- include/standby_pkg.sv ----
// Shared constants, types and register map of the standby controller.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus.
package standby_pkg;

    // Clock rate and basic timer 0 carry period.
    localparam int CLK_HZ          = 25_000_000;
    localparam int CARRY_PERIOD_MS = 125;
    localparam int CARRY_CYCLES    = CLK_HZ / 1000 * CARRY_PERIOD_MS;

    // Widths.
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int KEY_W  = 3;
    localparam int MASK_W = 4;
    localparam int ST_W   = 6;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CE_LEVEL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CLEAR    = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_ENABLE   = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_WAKE     = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_STATE    = 5'h14;

    // Field positions.
    localparam int CE_BIT        = 0;
    localparam int MASK_KEY_BIT  = 0;
    localparam int MASK_TMR_BIT  = 1;
    localparam int WAKE_CY_BIT   = 0;
    localparam int WAKE_KEY_LSB  = 1;
    localparam int STATE_MSK_LSB = 2;
    localparam int EV_WAKE       = 0;
    localparam int EV_STOP       = 1;
    localparam int EV_NOP        = 2;
    localparam int EV_CERST      = 3;
    localparam int EV_POR        = 4;
    localparam int EV_CARRY      = 5;

    // Reset values.
    localparam logic [ST_W-1:0]   ENABLE_RST = 6'h00;
    localparam logic [MASK_W-1:0] MASK_RST   = 4'h0;

    // Controller modes.
    typedef enum logic [1:0] {
        S_RUN,
        S_HALT,
        S_STOP,
        S_CE_WAIT
    } mode_e;

    // Instruction strobes from the CPU decoder.
    typedef struct packed {
        logic              halt;
        logic [MASK_W-1:0] mask;
        logic              stop;
    } cmd_s;

    // Clock and sequencing controls toward the rest of the chip.
    typedef struct packed {
        logic cpu_clk_en;
        logic osc_run;
        logic reset_pulse;
        logic resume_pulse;
        logic periph_init;
    } ctl_s;

endpackage

// ---- hdl/pin_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the pins are slow levels; each bit is treated on its own.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // Pin levels.
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_pins;
            o_sync <= meta_r;
        end
    end

endmodule
`default_nettype wire

// ---- hdl/carry_timer.sv ----
// Basic timer 0: emits a one-cycle carry pulse once per period.
// Assumes i_run is low while the oscillator is stopped.
`timescale 1ns/1ps
`default_nettype none
module carry_timer #(
    parameter int CYCLES = 3_125_000
) (
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_reset,
    // Control and carry.
    input  wire logic i_run,
    output logic      o_carry
);

    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          carry_nxt;

    // The counter only advances while the oscillator runs.
    always_comb begin
        cnt_nxt   = cnt_r;
        carry_nxt = 1'b0;
        if (i_run) begin
            if (cnt_r == LAST) begin
                cnt_nxt   = '0;
                carry_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + CW'(1);
            end
        end
    end

    // Counter and carry registers.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_r   <= '0;
            o_carry <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            o_carry <= carry_nxt;
        end
    end

endmodule
`default_nettype wire

// ---- hdl/standby_ctrl.sv ----
// Standby controller: halt, clock-stop, chip-enable reset and power-on.
// Assumes CPU instruction strobes are one-cycle pulses on i_clk and
// that pins are asynchronous; software uses Avalon-MM with waitrequest.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module standby_ctrl
    import standby_pkg::*;
#(
    parameter int CARRY_CYC = CARRY_CYCLES
) (
    // Clock and reset.
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    // External pins.
    input  wire logic              i_chip_enable,
    input  wire logic [KEY_W-1:0]  i_key_input_line,
    input  wire logic              i_supply_ok,
    // CPU instruction strobes.
    input  wire cmd_s              i_cmd,
    // Controls to the chip.
    output ctl_s                   o_ctl,
    output logic                   o_irq,
    // Avalon-MM slave.
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic              i_read,
    input  wire logic              i_write,
    input  wire logic [DATA_W-1:0] i_writedata,
    output logic [DATA_W-1:0]      o_readdata,
    output logic                   o_waitrequest
);

    // Register offset match, ignoring the byte lane bits.
    // The bus carries whole 32-bit words only, so the two low address bits
    // never select anything; any byte address inside a word still hits it.
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    // Synchronised pins and edge detection.
    // Logic reads a pin only after the second flip-flop, so a level that moves
    // near a clock edge can never split one decision into two different ones.
    logic [KEY_W+1:0] pins_s;
    logic             ce_s;
    logic             sup_s;
    logic [KEY_W-1:0] key_s;
    logic             ce_d_r;
    logic             sup_d_r;
    logic             ce_rise;
    logic             por_rise;
    logic             carry;

    // Controller state.
    mode_e             mode_r;
    mode_e             mode_nxt;
    logic [MASK_W-1:0] mask_r;
    logic [MASK_W-1:0] mask_nxt;
    logic              ce_pend_r;
    logic              ce_pend_nxt;
    ctl_s              ctl_nxt;
    logic [ST_W-1:0]   ev;
    logic              wake;

    // Register file state.
    logic [ST_W-1:0]   status_r;
    logic [ST_W-1:0]   status_nxt;
    logic [ST_W-1:0]   enable_r;
    logic [ST_W-1:0]   enable_nxt;
    logic              cy_flag_r;
    logic              cy_flag_nxt;
    logic              irq_nxt;
    logic              wait_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    logic              wr_go;
    logic              rd_go;

    // All external levels pass two flip-flops before use.
    // Supply, chip-enable and the key lines share one synchroniser, so they
    // all arrive with exactly the same two-cycle delay.
    pin_sync #(
        .WIDTH (KEY_W + 2)
    ) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pins  ({i_supply_ok, i_chip_enable, i_key_input_line}),
        .o_sync  (pins_s)
    );

    assign sup_s = pins_s[KEY_W+1];
    assign ce_s  = pins_s[KEY_W];
    assign key_s = pins_s[KEY_W-1:0];

    // Timer runs whenever the oscillator runs, halted CPU or not.
    // It freezes only in clock-stop, so its phase survives a halt and the
    // next carry after a chip-enable rise is never more than a period away.
    carry_timer #(
        .CYCLES (CARRY_CYC)
    ) u_timer (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_run   (o_ctl.osc_run),
        .o_carry (carry)
    );

    // Edges of the synchronised chip-enable and supply levels.
    // The delayed copies reset low, so a supply that is already good after
    // reset still gives one rise, which is the wanted power-on event.
    assign ce_rise  = ce_s & ~ce_d_r;
    assign por_rise = sup_s & ~sup_d_r;

    // Enabled wake sources ORed together.
    // The mask is latched with the halt strobe, so nothing that happens later
    // can change the wake sources of a halt that is already under way.
    assign wake = (mask_r[MASK_KEY_BIT] & (|key_s))
                | (mask_r[MASK_TMR_BIT] & carry);

    // Mode sequencing; resets take priority over every other event.
    // Stop is tested before halt, so a strobe pair never leaves the CPU in
    // halt while the oscillator is about to stop. A supply loss overrides
    // everything, a pending chip-enable reset included, because it erases it.
    always_comb begin
        mode_nxt    = mode_r;
        mask_nxt    = mask_r;
        ce_pend_nxt = ce_pend_r | ce_rise;
        ev          = '0;
        ctl_nxt     = '0;
        case (mode_r)
            S_RUN: begin
                if (i_cmd.stop && !ce_s) begin
                    mode_nxt            = S_STOP;
                    ctl_nxt.periph_init = 1'b1;
                    ev[EV_STOP]         = 1'b1;
                end else if (i_cmd.stop) begin
                    ev[EV_NOP] = 1'b1;
                end else if (i_cmd.halt) begin
                    mode_nxt = S_HALT;
                    mask_nxt = i_cmd.mask;
                end
            end
            S_HALT: begin
                if (wake) begin
                    mode_nxt             = S_RUN;
                    ctl_nxt.resume_pulse = 1'b1;
                    ev[EV_WAKE]          = 1'b1;
                end
            end
            S_STOP: begin
                if (ce_rise) begin
                    mode_nxt = S_CE_WAIT;
                end
            end
            S_CE_WAIT: begin
                mode_nxt = S_CE_WAIT;
            end
            default: begin
                mode_nxt = S_RUN;
            end
        endcase
        // Chip-enable reset waits for the next carry.
        // It applies in every mode, halt and run included, even with CE still high.
        if (ce_pend_r && carry) begin
            mode_nxt            = S_RUN;
            ce_pend_nxt         = 1'b0;
            ctl_nxt.reset_pulse = 1'b1;
            ctl_nxt.resume_pulse = 1'b0;
            ev[EV_CERST]        = 1'b1;
        end
        // A dead supply holds everything stopped until it returns.
        if (!sup_s) begin
            mode_nxt    = S_STOP;
            ce_pend_nxt = 1'b0;
            ctl_nxt     = '0;
            ev          = '0;
        end else if (por_rise) begin
            mode_nxt            = S_RUN;
            ce_pend_nxt         = 1'b0;
            ctl_nxt             = '0;
            ctl_nxt.reset_pulse = 1'b1;
            ev                  = '0;
            ev[EV_POR]          = 1'b1;
        end
        if (ctl_nxt.reset_pulse) begin
            mask_nxt = MASK_RST;
        end
        ev[EV_CARRY]       = carry;
        ctl_nxt.cpu_clk_en = (mode_nxt == S_RUN);
        ctl_nxt.osc_run    = (mode_nxt != S_STOP);
    end

    // Mode registers.
    // The controller leaves reset in clock-stop and waits for the supply,
    // so the first restart is always a power-on reset pulse.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            mode_r    <= S_STOP;
            mask_r    <= MASK_RST;
            ce_pend_r <= 1'b0;
            ce_d_r    <= 1'b0;
            sup_d_r   <= 1'b0;
            o_ctl     <= '0;
        end else begin
            mode_r    <= mode_nxt;
            mask_r    <= mask_nxt;
            ce_pend_r <= ce_pend_nxt;
            ce_d_r    <= ce_s;
            sup_d_r   <= sup_s;
            o_ctl     <= ctl_nxt;
        end
    end

    // Bus handshake: one wait cycle, then the access completes.
    // Read data are captured in the wait cycle, so they already stand in the
    // register while waitrequest is low and the master samples them.
    // A write is applied only at the edge at which waitrequest is low.
    assign rd_go    = i_read & o_waitrequest;
    assign wr_go    = i_write & ~o_waitrequest;
    assign wait_nxt = ~((i_read | i_write) & o_waitrequest);

    // Register writes and sticky flags; a set beats a same-cycle clear.
    // Software therefore never loses an event that arrives while it clears.
    always_comb begin
        enable_nxt  = enable_r;
        status_nxt  = status_r;
        cy_flag_nxt = cy_flag_r;
        if (wr_go && hit(i_address, OFS_ENABLE)) begin
            enable_nxt = i_writedata[ST_W-1:0];
        end
        if (wr_go && hit(i_address, OFS_CLEAR)) begin
            status_nxt = status_r & ~i_writedata[ST_W-1:0];
        end
        if (wr_go && hit(i_address, OFS_WAKE) && i_writedata[WAKE_CY_BIT]) begin
            cy_flag_nxt = 1'b0;
        end
        status_nxt  = status_nxt | ev;
        cy_flag_nxt = cy_flag_nxt | carry;
        irq_nxt     = |(status_nxt & enable_nxt);
    end

    // Read data selection; unmapped offsets read as zero.
    // The read word is held between reads, so a slow master sees a stable
    // value for as long as it likes.
    always_comb begin
        rdata_nxt = o_readdata;
        if (rd_go) begin
            rdata_nxt = '0;
            if (hit(i_address, OFS_CE_LEVEL)) begin
                rdata_nxt[CE_BIT] = ce_s;
            end else if (hit(i_address, OFS_STATUS)) begin
                rdata_nxt[ST_W-1:0] = status_r;
            end else if (hit(i_address, OFS_ENABLE)) begin
                rdata_nxt[ST_W-1:0] = enable_r;
            end else if (hit(i_address, OFS_WAKE)) begin
                rdata_nxt[WAKE_CY_BIT] = cy_flag_r;
                rdata_nxt[WAKE_KEY_LSB +: KEY_W] = key_s;
            end else if (hit(i_address, OFS_STATE)) begin
                rdata_nxt[1:0] = mode_r;
                rdata_nxt[STATE_MSK_LSB +: MASK_W] = mask_r;
            end else begin
                rdata_nxt = '0;
            end
        end
    end

    // Register file and bus registers.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            enable_r      <= ENABLE_RST;
            status_r      <= '0;
            cy_flag_r     <= 1'b0;
            o_irq         <= 1'b0;
            o_waitrequest <= 1'b1;
            o_readdata    <= '0;
        end else begin
            enable_r      <= enable_nxt;
            status_r      <= status_nxt;
            cy_flag_r     <= cy_flag_nxt;
            o_irq         <= irq_nxt;
            o_waitrequest <= wait_nxt;
            o_readdata    <= rdata_nxt;
        end
    end

endmodule
`default_nettype wire

// ---- tb/standby_ctrl_monitor.sv ----
// Checker for the standby controller, bound to its top module.
// Assumes pins stay steady for several cycles around each strobe.
`timescale 1ns/1ps
`default_nettype none
module standby_monitor
    import standby_pkg::*;
#(
    parameter int CARRY_CYC = CARRY_CYCLES
) (
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_reset,
    // Pins, strobes and controls.
    input  wire logic i_chip_enable,
    input  wire logic i_supply_ok,
    input  wire cmd_s i_cmd,
    input  wire ctl_s o_ctl
);
    localparam int TW = CARRY_CYC + 2;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Pin levels held long enough to pass the synchronisers, and accepted strobes.
    sequence ce_hi; i_chip_enable [*4]; endsequence
    sequence ce_lo; (!i_chip_enable && i_supply_ok) [*4]; endsequence
    sequence run_halt; o_ctl.cpu_clk_en && i_cmd.halt && !i_cmd.stop; endsequence
    sequence run_stop; o_ctl.cpu_clk_en && i_cmd.stop; endsequence
    AST_HALT_GATES: assert property (
        run_halt |=> !o_ctl.cpu_clk_en || o_ctl.reset_pulse) else $error("halt kept cpu clock");
    AST_HALT_KEEPS: assert property (
        run_halt |=> o_ctl.osc_run && !o_ctl.periph_init) else $error("halt disturbed periphery");
    AST_STOP_NOP: assert property (
        ce_hi ##0 run_stop |=> o_ctl.osc_run && !o_ctl.periph_init) else $error("stop not a no-op");
    AST_STOP_TAKES: assert property (
        ce_lo ##0 run_stop |=> !o_ctl.osc_run && !o_ctl.cpu_clk_en && o_ctl.periph_init)
        else $error("stop not taken");
    AST_TMR_WAKE: assert property (
        run_halt ##0 i_cmd.mask[MASK_TMR_BIT] |=> ##[0:TW] o_ctl.resume_pulse || o_ctl.reset_pulse)
        else $error("timer wake missing");
    AST_RESUME: assert property (
        o_ctl.resume_pulse |-> o_ctl.cpu_clk_en && o_ctl.osc_run && !$past(o_ctl.cpu_clk_en))
        else $error("bad resume");
    AST_RESTART: assert property (
        o_ctl.reset_pulse |-> o_ctl.cpu_clk_en && o_ctl.osc_run && !o_ctl.resume_pulse)
        else $error("bad restart");
    AST_OSC_OFF: assert property (
        !o_ctl.osc_run |-> !o_ctl.cpu_clk_en && !o_ctl.resume_pulse) else $error("cpu runs unclocked");
    AST_SLEEP_CAUSE: assert property (
        $fell(o_ctl.cpu_clk_en) && o_ctl.osc_run |-> $past(i_cmd.halt)) else $error("stray halt");
endmodule
bind standby_ctrl standby_monitor #(.CARRY_CYC(CARRY_CYC)) mon_u (
    .i_clk, .i_reset, .i_chip_enable, .i_supply_ok, .i_cmd, .o_ctl);
`default_nettype wire

// ---- tb/firmware_model.sv ----
// Firmware and pin model: strobes instructions, drives key, chip-enable and supply.
// Assumes the controller takes strobes only while the CPU clock runs.
`timescale 1ns/1ps
`default_nettype none
module firmware_model
    import standby_pkg::*;
(
    // Clock and CPU run level.
    input  wire logic        i_clk,
    input  wire logic        i_cpu_run,
    // Strobes and pins toward the controller.
    output cmd_s             o_cmd,
    output logic             o_ce,
    output logic [KEY_W-1:0] o_keys,
    output logic             o_supply
);
    // Idle: keys rest on their pull-downs, supply starts off.
    initial begin
        o_cmd    = '0;
        o_ce     = 1'b0;
        o_keys   = '0;
        o_supply = 1'b0;
    end
    // Sets pin levels just after the next rising edge.
    task automatic pins(input logic ce, input logic [KEY_W-1:0] k, input logic s);
        @(posedge i_clk);
        o_ce     <= ce;
        o_keys   <= k;
        o_supply <= s;
    endtask
    // Issues one strobe once the CPU runs, or after 100 cycles if it never does; a stop always carries a zero operand.
    task automatic issue(input logic halt, input logic [MASK_W-1:0] m);
        repeat (100) begin
            @(posedge i_clk);
            if (i_cpu_run === 1'b1) break;
        end
        o_cmd <= '{halt: halt, mask: halt ? m : 4'h0, stop: !halt};
        @(posedge i_clk);
        o_cmd <= '0;
    endtask
endmodule
`default_nettype wire

// ---- tb/test_standby_ctrl.sv ----
// Self-checking bench for the standby controller.
// Assumes the firmware model drives pins and strobes; the bus is driven here.
`timescale 1ns/1ps
`default_nettype none
module test_standby_ctrl import standby_pkg::*;;
    typedef struct packed {
        logic [DATA_W-1:0] m;
        logic [DATA_W-1:0] v;
    } note_s;
    localparam logic [1:0] EV_RST = 2'b10;
    localparam logic [1:0] EV_RES = 2'b01;
    logic              i_clk = 1'b0;
    logic              i_reset = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic              read = 1'b0;
    logic              write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [DATA_W-1:0] rdata;
    logic              waitreq;
    logic              irq;
    logic              ce;
    logic              supply;
    logic [KEY_W-1:0]  keys;
    cmd_s              cmd;
    ctl_s              ctl;
    note_s             exp_q[$];
    logic [1:0]        ev_q[$];
    logic [31:0]       seed = 32'h8DB7;
    int                num_errors = 0;
    int                samples_checked = 0;
    // Free-running 25 MHz clock.
    always #20 i_clk = ~i_clk;
    standby_ctrl #(.CARRY_CYC(20)) dut_u (.i_clk(i_clk), .i_reset(i_reset),
        .i_chip_enable(ce), .i_key_input_line(keys), .i_supply_ok(supply), .i_cmd(cmd),
        .o_ctl(ctl), .o_irq(irq), .i_address(address), .i_read(read), .i_write(write),
        .i_writedata(writedata), .o_readdata(rdata), .o_waitrequest(waitreq));
    firmware_model fw_u (.i_clk(i_clk), .i_cpu_run(ctl.cpu_clk_en), .o_cmd(cmd), .o_ce(ce),
        .o_keys(keys), .o_supply(supply));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [DATA_W-1:0] e, g, m);
        samples_checked++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e & m, g & m);
        end
    endtask
    // One bus access; a read notes its expected word, compared at completion.
    // The wait ends only when waitrequest drops; the watchdog bounds a hang.
    task automatic bus(input logic we, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] m);
        @(posedge i_clk);
        write     <= we;
        read      <= !we;
        address   <= a;
        writedata <= d;
        if (!we) exp_q.push_back('{m, d});
        do begin
            @(posedge i_clk);
        end while (waitreq !== 1'b0);
        write <= 1'b0;
        read  <= 1'b0;
    endtask
    // Waits a bounded time for every noted pulse to be seen.
    task automatic wait_ev();
        for (int k = 0; k < 300 && ev_q.size() > 0; k++) @(posedge i_clk);
        if (ev_q.size() > 0) chk("pulse wait", 32'h0, 32'h1, 32'h1);
        ev_q.delete();
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Output watcher: each read completion and each pulse takes the oldest note.
    always @(posedge i_clk) begin
        if (read && waitreq === 1'b0) begin
            if (exp_q.size() > 0) chk("readdata", exp_q[0].v, rdata, exp_q[0].m);
            else chk("read unexpected", 32'h0, 32'h1, 32'h1);
            if (exp_q.size() > 0) exp_q.pop_front();
        end
        if (!i_reset && {ctl.reset_pulse, ctl.resume_pulse} !== 2'b00) begin
            chk("pulse", {30'h0, (ev_q.size() > 0) ? ev_q[0] : 2'b00},
                {30'h0, ctl.reset_pulse, ctl.resume_pulse}, 32'h3);
            if (ev_q.size() > 0) ev_q.pop_front();
        end
    end
    // Watchdog cuts a hang short.
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        logic [KEY_W-1:0] k;
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        ev_q.push_back(EV_RST);
        fw_u.pins(1'b0, 3'h0, 1'b1);
        wait_ev();
        bus(1'b0, OFS_STATE, 32'h0, 32'h3);
        bus(1'b0, OFS_ENABLE, {26'h0, ENABLE_RST}, 32'hFFFFFFFF);
        bus(1'b0, 5'h18, 32'h0, 32'hFFFFFFFF);
        bus(1'b0, OFS_CE_LEVEL, 32'h0, 32'h1);
        ev_q.push_back(EV_RST);
        fw_u.pins(1'b1, 3'h0, 1'b1);
        wait_ev();
        bus(1'b0, OFS_CE_LEVEL, 32'h1, 32'h1);
        bus(1'b1, OFS_CLEAR, 32'h3F, 32'h0);
        fw_u.issue(1'b0, 4'h0);
        bus(1'b0, OFS_STATUS, 32'h4, 32'h7);
        bus(1'b1, OFS_ENABLE, 32'h1, 32'h0);
        ev_q.push_back(EV_RES);
        fw_u.issue(1'b1, 4'h2);
        wait_ev();
        bus(1'b0, OFS_WAKE, 32'h1, 32'h1);
        bus(1'b0, OFS_STATE, 32'h0, 32'h3);
        chk("irq", 32'h1, {31'h0, irq}, 32'h1);
        bus(1'b1, OFS_ENABLE, 32'h0, 32'h0);
        repeat (2) @(posedge i_clk);
        chk("irq masked", 32'h0, {31'h0, irq}, 32'h1);
        bus(1'b1, OFS_CLEAR, 32'h1, 32'h0);
        bus(1'b1, OFS_ENABLE, 32'h1, 32'h0);
        repeat (2) @(posedge i_clk);
        chk("irq cleared", 32'h0, {31'h0, irq}, 32'h1);
        // Key wake with random key patterns; no wake before a key rises.
        repeat (3) begin
            seed = lfsr(seed);
            k = seed[2:0] | 3'h1;
            fw_u.issue(1'b1, 4'h1);
            repeat (8) @(posedge i_clk);
            ev_q.push_back(EV_RES);
            fw_u.pins(1'b1, k, 1'b1);
            wait_ev();
            bus(1'b0, OFS_WAKE, {28'h0, k, 1'b0}, 32'hE);
            fw_u.pins(1'b1, 3'h0, 1'b1);
        end
        // Halt with no wake source set, chip-enable low; only a chip-enable reset ends it.
        fw_u.pins(1'b0, 3'h7, 1'b1);
        repeat (4) @(posedge i_clk);
        fw_u.issue(1'b1, 4'h0);
        bus(1'b0, OFS_STATE, 32'h1, 32'h3);
        repeat (40) @(posedge i_clk);
        ev_q.push_back(EV_RST);
        fw_u.pins(1'b1, 3'h0, 1'b1);
        wait_ev();
        // Clock-stop with chip-enable low, left by a chip-enable rise.
        fw_u.pins(1'b0, 3'h0, 1'b1);
        repeat (4) @(posedge i_clk);
        bus(1'b1, OFS_CLEAR, 32'h3F, 32'h0);
        fw_u.issue(1'b0, 4'h0);
        bus(1'b0, OFS_STATE, 32'h2, 32'h3);
        ev_q.push_back(EV_RST);
        fw_u.pins(1'b1, 3'h0, 1'b1);
        wait_ev();
        bus(1'b0, OFS_STATUS, 32'hA, 32'hF);
        // Supply loss and return.
        fw_u.pins(1'b1, 3'h0, 1'b0);
        repeat (6) @(posedge i_clk);
        ev_q.push_back(EV_RST);
        fw_u.pins(1'b1, 3'h0, 1'b1);
        wait_ev();
        bus(1'b0, OFS_STATUS, 32'h10, 32'h10);
        repeat (4) @(posedge i_clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
